/* File: design/lucs_clock_synth.v */
// clock synthesizer control for a fourteen channel t1/e1 line unit
`timescale 1ns/1ns
`include "lucs_map.vh"

module lucs_clock_synth #(
    parameter [13:0] PER_8K_CYCLES  = `LUCS_PER_8K_DEF,
    parameter [13:0] PER_16K_CYCLES = `LUCS_PER_16K_DEF
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire        ref_clk_in,
    input  wire [3:0]  input_reference_select,
    input  wire        single_rate_gating_disable,
    input  wire        device_rate_e1,
    input  wire [13:0] chan_eq_e1,
    input  wire [1:0]  nx_select,
    output reg  [13:0] chan_line_clk,
    output reg         clk_t1_ref,
    output reg         clk_e1_ref,
    output reg         clk_8k_ref,
    output reg         clk_nxt1_ref,
    output reg         clk_nxe1_ref,
    output reg         ref_lock,
    output reg         gating_active
);

    // reference periods in system clock cycles, held 32 bits wide so
    // that the cut to the 14-bit period counter is an explicit select
    localparam [31:0] CYC_2048K  = `LUCS_CLK_HZ / `LUCS_HZ_2048K;
    localparam [31:0] CYC_1544K  = `LUCS_CLK_HZ / `LUCS_HZ_1544K;
    localparam [31:0] CYC_56K    = `LUCS_CLK_HZ / `LUCS_HZ_56K;
    localparam [31:0] CYC_64K    = `LUCS_CLK_HZ / `LUCS_HZ_64K;
    localparam [31:0] CYC_128K   = `LUCS_CLK_HZ / `LUCS_HZ_128K;
    localparam [31:0] CYC_256K   = `LUCS_CLK_HZ / `LUCS_HZ_256K;
    // the fastest multiplied reference is only six cycles long, so its
    // window is only the one guard cycle either side, its eighth being zero
    localparam [31:0] CYC_4096K  = `LUCS_CLK_HZ / `LUCS_HZ_4096K;
    localparam [31:0] CYC_3088K  = `LUCS_CLK_HZ / `LUCS_HZ_3088K;
    localparam [31:0] CYC_8192K  = `LUCS_CLK_HZ / `LUCS_HZ_8192K;
    localparam [31:0] CYC_6176K  = `LUCS_CLK_HZ / `LUCS_HZ_6176K;
    localparam [31:0] CYC_16384K = `LUCS_CLK_HZ / `LUCS_HZ_16384K;
    localparam [31:0] CYC_12352K = `LUCS_CLK_HZ / `LUCS_HZ_12352K;

    // expected system clock cycles per reference period
    function [13:0] ref_cycles;
        input [3:0] sel;
        begin
            case (sel)
                `LUCS_SEL_2048K,
                `LUCS_SEL_2048K_ALT:
                    ref_cycles = CYC_2048K[13:0];
                `LUCS_SEL_1544K,
                `LUCS_SEL_1544K_ALT:
                    ref_cycles = CYC_1544K[13:0];
                `LUCS_SEL_8K:     ref_cycles = PER_8K_CYCLES;
                `LUCS_SEL_16K:    ref_cycles = PER_16K_CYCLES;
                `LUCS_SEL_56K:    ref_cycles = CYC_56K[13:0];
                `LUCS_SEL_64K:    ref_cycles = CYC_64K[13:0];
                `LUCS_SEL_128K:   ref_cycles = CYC_128K[13:0];
                `LUCS_SEL_256K:   ref_cycles = CYC_256K[13:0];
                `LUCS_SEL_4096K:  ref_cycles = CYC_4096K[13:0];
                `LUCS_SEL_3088K:  ref_cycles = CYC_3088K[13:0];
                `LUCS_SEL_8192K:  ref_cycles = CYC_8192K[13:0];
                `LUCS_SEL_6176K:  ref_cycles = CYC_6176K[13:0];
                `LUCS_SEL_16384K: ref_cycles = CYC_16384K[13:0];
                `LUCS_SEL_12352K: ref_cycles = CYC_12352K[13:0];
                // all sixteen codes are decoded above; never taken
                default:          ref_cycles = PER_8K_CYCLES;
            endcase
        end
    endfunction

    // one accumulator step, held at zero while stopped
    function [23:0] acc_step;
        input [23:0] acc;
        input [23:0] inc;
        input        run;
        begin
            if (run) begin
                acc_step = acc + inc;
            end else begin
                acc_step = 24'h000000;
            end
        end
    endfunction

    reg  [23:0] acc_t1;
    reg  [23:0] acc_e1;
    reg  [23:0] acc_8k;
    reg  [23:0] acc_nxt1;
    reg  [23:0] acc_nxe1;
    reg         ref_prev;
    reg  [13:0] per_cnt;
    reg  [1:0]  hit_cnt;
    reg  [3:0]  sel_prev;

    wire        t1_run;
    wire        e1_run;
    wire        k8_run;
    wire [13:0] per_exp;
    wire [13:0] per_lo;
    wire [13:0] per_hi;
    wire        ref_rise;
    wire        per_ok;
    wire [23:0] inc_nxt1;
    wire [23:0] inc_nxe1;

    // gating is on whenever the disable bit is low
    assign t1_run = single_rate_gating_disable | ~device_rate_e1;
    assign e1_run = single_rate_gating_disable | device_rate_e1;
    // 8 kHz survives only in e1 mode or with gating off
    assign k8_run = single_rate_gating_disable | device_rate_e1;

    // multiplied references; 8x e1 is 16.384 MHz, so edges jitter by 10 ns
    assign inc_nxt1 = `LUCS_INC_T1 << nx_select;
    assign inc_nxe1 = `LUCS_INC_E1 << nx_select;

    // reference period window, one eighth plus one cycle either side
    assign per_exp  = ref_cycles(input_reference_select);
    assign per_lo   = per_exp - (per_exp >> 3) - 14'h0001;
    assign per_hi   = per_exp + (per_exp >> 3) + 14'h0001;
    // ref_prev resets low, the idle level, so a reference already high at reset release reads as an edge
    assign ref_rise = ref_clk_in & ~ref_prev;
    assign per_ok   = (per_cnt >= per_lo) && (per_cnt <= per_hi);

    // reference watch: lock after four good periods in a row
    always @(posedge mclk) begin
        if (rst) begin
            ref_prev <= 1'b0;
            per_cnt  <= 14'h0000;
            hit_cnt  <= 2'h0;
            sel_prev <= 4'h0;
            ref_lock <= 1'b0;
        end else begin
            ref_prev <= ref_clk_in;
            sel_prev <= input_reference_select;
            if (sel_prev != input_reference_select) begin
                // a new selector invalidates what was measured
                per_cnt  <= 14'h0000;
                hit_cnt  <= 2'h0;
                ref_lock <= 1'b0;
            end else if (ref_rise) begin
                // an edge restarts the count; the first after a clear is judged on the cycles since the clear
                per_cnt <= 14'h0001;
                if (!per_ok) begin
                    hit_cnt  <= 2'h0;
                    ref_lock <= 1'b0;
                end else if (hit_cnt == `LUCS_LOCK_HITS) begin
                    // lock then stands until a bad period, a loss or a new code
                    ref_lock <= 1'b1;
                end else begin
                    hit_cnt <= hit_cnt + 2'h1;
                end
            end else if (per_cnt > per_hi) begin
                // reference lost: drop lock without waiting for an edge
                hit_cnt  <= 2'h0;
                ref_lock <= 1'b0;
            end else begin
                per_cnt <= per_cnt + 14'h0001;
            end
        end
    end

    // synthesizers run only while the reference is locked
    // a gated reference comes back from phase zero, not where it stopped
    always @(posedge mclk) begin
        if (rst) begin
            acc_t1   <= 24'h000000;
            acc_e1   <= 24'h000000;
            acc_8k   <= 24'h000000;
            acc_nxt1 <= 24'h000000;
            acc_nxe1 <= 24'h000000;
        end else begin
            acc_t1   <= acc_step(acc_t1, `LUCS_INC_T1,
                                 t1_run & ref_lock);
            acc_e1   <= acc_step(acc_e1, `LUCS_INC_E1,
                                 e1_run & ref_lock);
            acc_8k   <= acc_step(acc_8k, `LUCS_INC_8K,
                                 k8_run & ref_lock);
            acc_nxt1 <= acc_step(acc_nxt1, inc_nxt1,
                                 t1_run & ref_lock);
            acc_nxe1 <= acc_step(acc_nxe1, inc_nxe1,
                                 e1_run & ref_lock);
        end
    end

    // registered clock outputs and per channel selection
    // outputs trail the accumulator msb by one flop
    always @(posedge mclk) begin
        if (rst) begin
            clk_t1_ref    <= 1'b0;
            clk_e1_ref    <= 1'b0;
            clk_8k_ref    <= 1'b0;
            clk_nxt1_ref  <= 1'b0;
            clk_nxe1_ref  <= 1'b0;
            chan_line_clk <= 14'h0000;
            gating_active <= 1'b1;
        end else begin
            clk_t1_ref    <= acc_t1[23];
            clk_e1_ref    <= acc_e1[23];
            clk_8k_ref    <= acc_8k[23];
            clk_nxt1_ref  <= acc_nxt1[23];
            clk_nxe1_ref  <= acc_nxe1[23];
            // each channel picks independently from its own setting
            chan_line_clk <= (chan_eq_e1 & {14{acc_e1[23]}})
                           | (~chan_eq_e1 & {14{acc_t1[23]}});
            gating_active <= ~single_rate_gating_disable;
        end
    end

endmodule // lucs_clock_synth

/* File: design/lucs_map.vh */
// constants for the line unit clock synthesizer control
`ifndef LUCS_MAP_VH
`define LUCS_MAP_VH

// system clock rate
`define LUCS_CLK_HZ          100000000

// reference selector codes
`define LUCS_SEL_2048K       4'h0
`define LUCS_SEL_1544K       4'h1
`define LUCS_SEL_8K          4'h2
`define LUCS_SEL_16K         4'h3
`define LUCS_SEL_56K         4'h4
`define LUCS_SEL_64K         4'h5
`define LUCS_SEL_128K        4'h6
`define LUCS_SEL_256K        4'h7
`define LUCS_SEL_4096K       4'h8
`define LUCS_SEL_3088K       4'h9
`define LUCS_SEL_8192K       4'hA
`define LUCS_SEL_6176K       4'hB
`define LUCS_SEL_16384K      4'hC
`define LUCS_SEL_12352K      4'hD
`define LUCS_SEL_2048K_ALT   4'hE
`define LUCS_SEL_1544K_ALT   4'hF

// reference frequencies in hertz
`define LUCS_HZ_2048K        2048000
`define LUCS_HZ_1544K        1544000
`define LUCS_HZ_8K           8000
`define LUCS_HZ_16K          16000
`define LUCS_HZ_56K          56000
`define LUCS_HZ_64K          64000
`define LUCS_HZ_128K         128000
`define LUCS_HZ_256K         256000
`define LUCS_HZ_4096K        4096000
`define LUCS_HZ_3088K        3088000
`define LUCS_HZ_8192K        8192000
`define LUCS_HZ_6176K        6176000
`define LUCS_HZ_16384K       16384000
`define LUCS_HZ_12352K       12352000

// reference period counter
`define LUCS_PER_W           14
`define LUCS_PER_8K_DEF      14'h30D4
`define LUCS_PER_16K_DEF     14'h186A
`define LUCS_LOCK_HITS       2'h3

// phase accumulator steps, f / clk * 2^24, rounded down
`define LUCS_ACC_W           24
`define LUCS_INC_T1          24'h03F3E0
`define LUCS_INC_E1          24'h053E2D
`define LUCS_INC_8K          24'h00053E

// fourteen channels
`define LUCS_CHANNELS        14

`endif

/* File: tb/lucs_assertions.sv */
// assertions on the clock synthesizer control ports
`timescale 1ns/1ns
module lucs_checker (
    input wire        mclk,
    input wire        rst,
    input wire        ref_clk_in,
    input wire [3:0]  input_reference_select,
    input wire        single_rate_gating_disable,
    input wire        device_rate_e1,
    input wire [13:0] chan_eq_e1,
    input wire [1:0]  nx_select,
    input wire [13:0] chan_line_clk,
    input wire        clk_t1_ref,
    input wire        clk_e1_ref,
    input wire        clk_8k_ref,
    input wire        clk_nxt1_ref,
    input wire        clk_nxe1_ref,
    input wire        ref_lock,
    input wire        gating_active
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // gating on, one device rate, channel rates held
    sequence s_t1_only;
        !single_rate_gating_disable && !device_rate_e1 && $stable(chan_eq_e1);
    endsequence
    sequence s_e1_only;
        !single_rate_gating_disable && device_rate_e1 && $stable(chan_eq_e1);
    endsequence
    AST_RST_STATE: assert property (disable iff (1'b0)
        rst |=> gating_active && chan_line_clk == 14'h0000 && !ref_lock)
        else $error("reset state wrong");
    AST_GATE_FOLLOW: assert property (!$past(rst) |->
        gating_active == !$past(single_rate_gating_disable))
        else $error("gating flag does not follow disable bit");
    AST_E1_STOP: assert property (s_t1_only [*4] |->
        !clk_e1_ref && !clk_nxe1_ref && !clk_8k_ref)
        else $error("e1 or 8k reference runs in t1 only mode");
    AST_T1_STOP: assert property (s_e1_only [*4] |->
        !clk_t1_ref && !clk_nxt1_ref) else $error("t1 reference runs");
    AST_CH_T1: assert property (s_t1_only [*4] |->
        (chan_line_clk & chan_eq_e1) == 14'h0000)
        else $error("e1 channel clocked in t1 only mode");
    AST_CH_E1: assert property (s_e1_only [*4] |->
        (chan_line_clk & ~chan_eq_e1) == 14'h0000)
        else $error("t1 channel clocked in e1 only mode");
    AST_NO_REF: assert property (!ref_lock [*3] |->
        chan_line_clk == 14'h0000 && !clk_t1_ref && !clk_e1_ref)
        else $error("clocks without a valid reference");
    AST_SEL_DROP: assert property (
        $changed(input_reference_select) |-> ##[1:2] !ref_lock)
        else $error("lock kept over selector change");
endmodule // lucs_checker

bind lucs_clock_synth lucs_checker chk (.mclk(mclk), .rst(rst),
    .ref_clk_in(ref_clk_in), .input_reference_select(input_reference_select),
    .single_rate_gating_disable(single_rate_gating_disable),
    .device_rate_e1(device_rate_e1), .chan_eq_e1(chan_eq_e1),
    .nx_select(nx_select), .chan_line_clk(chan_line_clk),
    .clk_t1_ref(clk_t1_ref), .clk_e1_ref(clk_e1_ref), .clk_8k_ref(clk_8k_ref),
    .clk_nxt1_ref(clk_nxt1_ref), .clk_nxe1_ref(clk_nxe1_ref),
    .ref_lock(ref_lock), .gating_active(gating_active));

/* File: tb/lucs_clock_synth_bench.sv */
// self-checking bench for the clock synthesizer control
`timescale 1ns/1ns
module lucs_clock_synth_bench;
    reg         mclk = 1'b0, rst = 1'b1, dis = 1'b0, dev = 1'b0;
    reg  [3:0]  sel = 4'h2;
    reg  [10:0] period = 11'h064;
    reg  [13:0] eq = 14'h2A55;
    reg  [1:0]  nx = 2'h0;
    wire        ref_in, t1, e1, k8, nt1, ne1, lock, gact;
    wire [13:0] chan;
    wire [18:0] outs = {chan, t1, e1, k8, nt1, ne1};
    integer     fails = 0, n_compared = 0, cnt [0:18], i, k, lo;
    always #5 mclk = ~mclk;
    lucs_ref_source src (.mclk(mclk), .run(1'b1), .period(period),
        .ref_clk_in(ref_in));
    lucs_clock_synth #(.PER_8K_CYCLES(14'h0064), .PER_16K_CYCLES(14'h0032))
    dut (.mclk(mclk), .rst(rst), .ref_clk_in(ref_in),
        .input_reference_select(sel), .single_rate_gating_disable(dis),
        .device_rate_e1(dev), .chan_eq_e1(eq), .nx_select(nx),
        .chan_line_clk(chan), .clk_t1_ref(t1), .clk_e1_ref(e1),
        .clk_8k_ref(k8), .clk_nxt1_ref(nt1), .clk_nxe1_ref(ne1),
        .ref_lock(lock), .gating_active(gact));
    // one comparison, reported at once
    task check(input ok, input [8*24-1:0] msg);
        begin
            n_compared = n_compared + 1;
            if (ok !== 1'b1) begin
                fails = fails + 1;
                $display("[FAIL] %0t %0s", $time, msg);
            end
        end
    endtask
    // rising edges of every clock output over n cycles
    task measure(input integer n);
        reg [18:0] prev;
        begin
            prev = outs;
            for (k = 0; k < 19; k = k + 1) cnt[k] = 0;
            repeat (n) begin
                @(negedge mclk);
                for (k = 0; k < 19; k = k + 1)
                    if (outs[k] === 1'b1 && prev[k] === 1'b0)
                        cnt[k] = cnt[k] + 1;
                prev = outs;
            end
        end
    endtask
    // new selector and reference; lock must drop, then return
    task t_lock(input [3:0] code, input [10:0] per);
        begin
            sel = code;
            period = per;
            repeat (2) @(negedge mclk);
            check(lock === 1'b0, "lock kept over change");
            repeat (10 * per) if (lock !== 1'b1) @(negedge mclk);
            check(lock === 1'b1, "no lock on reference");
        end
    endtask
    // gating mode: rates of the references and channels over 10 us
    task t_mode(input d, input r);
        reg rt, re, rc, rx;
        begin
            rt = d | ~r;
            re = d | r;
            dis = d;
            dev = r;
            repeat (6) @(negedge mclk);
            check(gact === ~d, "gating flag");
            measure(1000);
            check((cnt[4] >= 14 && cnt[4] <= 17) == rt, "t1 rate");
            check((cnt[3] >= 19 && cnt[3] <= 22) == re, "e1 rate");
            check(re || cnt[2] == 0, "8k not stopped");
            check((cnt[1] > 0) == rt && (cnt[0] > 0) == re, "nx");
            for (i = 0; i < 14; i = i + 1) begin
                lo = eq[i] ? 19 : 14;
                rx = eq[i] ? re : rt;
                rc = cnt[i+5] >= lo && cnt[i+5] <= lo + 3;
                check(rc == rx, "channel clock");
            end
        end
    endtask
    // verdict and end of run
    task wrap_up;
        begin
            $display("compared %0d, failed %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // main sequence, inputs change at the falling edge
    initial begin
        repeat (4) @(negedge mclk);
        check(gact === 1'b1 && outs === 19'h0, "reset state");
        rst = 1'b0;
        @(negedge mclk);
        t_lock(4'h0, 11'h031);
        t_lock(4'h1, 11'h041);
        t_lock(4'hE, 11'h031);
        t_lock(4'hF, 11'h041);
        t_lock(4'h8, 11'h018);
        t_lock(4'h9, 11'h020);
        t_lock(4'hA, 11'h00C);
        t_lock(4'hB, 11'h010);
        t_lock(4'hC, 11'h006);
        t_lock(4'hD, 11'h008);
        t_lock(4'h4, 11'h6F9);
        t_lock(4'h5, 11'h61A);
        t_lock(4'h6, 11'h30D);
        t_lock(4'h7, 11'h186);
        t_lock(4'h3, 11'h032);
        t_lock(4'h2, 11'h064);
        t_mode(1'b0, 1'b0);
        t_mode(1'b1, 1'b0);
        for (i = 0; i < 4; i = i + 1) begin
            nx = i[1:0];
            repeat (4) @(negedge mclk);
            measure(1000);
            lo = (1544 << i) / 100;
            check(cnt[1] >= lo - 1 && cnt[1] <= lo + 2, "nx t1");
            lo = (2048 << i) / 100;
            check(cnt[0] >= lo - 1 && cnt[0] <= lo + 2, "nx e1");
        end
        t_mode(1'b0, 1'b1);
        measure(26000);
        check(cnt[2] >= 2 && cnt[2] <= 3, "8k rate in e1 mode");
        wrap_up;
    end
    // hang guard, well past the expected run length
    initial begin
        repeat (90000) @(posedge mclk);
        fails = fails + 1;
        wrap_up;
    end
endmodule // lucs_clock_synth_bench

/* File: tb/lucs_ref_source.sv */
// external reference clock source model
`timescale 1ns/1ns
module lucs_ref_source (
    input  wire       mclk,
    input  wire       run,
    input  wire [10:0] period,
    output reg         ref_clk_in
);
    reg [10:0] cnt = 11'h000;
    initial ref_clk_in = 1'b0;
    // square wave of the chosen period, held low while stopped
    always @(posedge mclk) begin
        if (!run || cnt + 11'h001 >= period) begin
            cnt <= 11'h000; // wrap also covers a period shortened mid-count
        end else begin
            cnt <= cnt + 11'h001;
        end
        ref_clk_in <= run && (cnt < {1'b0, period[10:1]});
    end
endmodule // lucs_ref_source
